// file: verilog/spc_regs.svh
// Operation
// - Position error above the minimum threshold drives full PWM.
// - Each position sample with error not above the minimum threshold adds the error into the integral sum.
// - Error and the new sum (old sum plus error) of opposite sign clear the sum.
// - Integral sum is clamped to the configured maximum.
// - Differential error is present minus previous error; present error is kept.
// - Output is gained P, I and D terms summed, then scaled down.
// - Scaled magnitude above the PWM limit sends maximum PWM.
// - Output sign drives direction; magnitude becomes the PWM duty.
// - A command with nonzero speed ceiling starts a trapezoidal profile.
// - Ramp rate is one count per sample, one sample per 500 us.
// - Ramp-up and ramp-down spans equal the speed ceiling in samples.
// - Cruise-end mark is distance to target less ramp distance.
// - Profile-finish mark is cruise-end plus twice the ramp-up span.
// - Velocity loop runs until finish mark, then position loop takes over.
// - Profile time counts once per tick while below the finish mark.
// - During ramp-up the setpoint is ramp rate times profile time.
// - Between ramp-up and cruise-end the setpoint holds the speed ceiling.
// - After cruise-end the setpoint follows the decel reference tick.
// - A zero speed ceiling uses the position loop alone.
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH

`define SPC_POS_W 32
`define SPC_SPD_W 16
`define SPC_GAIN_W 16
`define SPC_PWM_W 8
`define SPC_SHIFT_W 5
`define SPC_RAMP_RATE 1
`define SPC_CLK_PERIOD_NS 25
`define SPC_SAMPLE_PERIOD_US 500
`define SPC_SAMPLE_CYCLES ((`SPC_SAMPLE_PERIOD_US * 1000) / `SPC_CLK_PERIOD_NS)
`define SPC_DIR_RESET 1'b1
`define SPC_TIME_RESET 0

`endif

// file: verilog/spc_pkg.sv
`default_nettype none
package spc_pkg;
	typedef enum logic [1:0] {
		SPC_MODE_IDLE,
		SPC_MODE_POSITION,
		SPC_MODE_PROFILE
	} spc_mode_t;
endpackage
`default_nettype wire

// file: verilog/spc_pid_math.sv
`timescale 1ns/100ps
`default_nettype none
`include "spc_regs.svh"

module spc_pid_math #(
	parameter int POS_W = `SPC_POS_W,
	parameter int GAIN_W = `SPC_GAIN_W,
	parameter int PWM_W = `SPC_PWM_W,
	parameter int SHIFT_W = `SPC_SHIFT_W
) (
	input wire logic signed [POS_W-1:0] i_err,
	input wire logic signed [POS_W-1:0] i_int_sum,
	input wire logic signed [POS_W-1:0] i_prev_err,
	input wire logic [GAIN_W-1:0] i_kp,
	input wire logic [GAIN_W-1:0] i_ki,
	input wire logic [GAIN_W-1:0] i_kd,
	input wire logic [POS_W-2:0] i_int_max,
	input wire logic [SHIFT_W-1:0] i_scale_shift,
	input wire logic [PWM_W-1:0] i_pwm_limit,
	output logic signed [POS_W-1:0] o_next_int_sum,
	output logic [PWM_W-1:0] o_pwm_duty,
	output logic o_dir
);
	localparam int ACC_W = POS_W + GAIN_W + 4;

	logic signed [POS_W:0] sum_raw;
	logic signed [POS_W:0] max_pos;
	logic signed [POS_W:0] min_neg;
	logic signed [POS_W:0] diff;
	logic signed [ACC_W-1:0] acc;
	logic signed [ACC_W-1:0] scaled;
	logic [ACC_W-1:0] mag;

	// Gain times value with the gain taken as a positive number.
	function automatic logic signed [ACC_W-1:0] gained(input logic [GAIN_W-1:0] gain,
		input logic signed [POS_W:0] value);
		gained = ACC_W'(signed'({1'b0, gain})) * ACC_W'(value);
	endfunction

	always_comb
	begin
		sum_raw = (POS_W+1)'(i_int_sum) + (POS_W+1)'(i_err);
		max_pos = signed'({2'b00, i_int_max});
		min_neg = -max_pos;
		if (i_err != '0 && sum_raw != '0 && (i_err[POS_W-1] != sum_raw[POS_W]))
			o_next_int_sum = '0;
		else if (sum_raw > max_pos)
			o_next_int_sum = max_pos[POS_W-1:0];
		else if (sum_raw < min_neg)
			o_next_int_sum = min_neg[POS_W-1:0];
		else
			o_next_int_sum = sum_raw[POS_W-1:0];
		diff = (POS_W+1)'(i_err) - (POS_W+1)'(i_prev_err);
		acc = gained(i_kp, (POS_W+1)'(i_err)) + gained(i_ki, (POS_W+1)'(o_next_int_sum))
			+ gained(i_kd, diff);
		scaled = acc >>> i_scale_shift;
		mag = scaled[ACC_W-1] ? $unsigned(-scaled) : $unsigned(scaled);
		o_dir = ~scaled[ACC_W-1];
		if (mag > ACC_W'(i_pwm_limit))
			o_pwm_duty = '1;
		else
			o_pwm_duty = mag[PWM_W-1:0];
	end
endmodule // spc_pid_math
`default_nettype wire

// file: verilog/spc_controller.sv
`timescale 1ns/100ps
`default_nettype none
`include "spc_regs.svh"

module spc_controller #(
	parameter int POS_W = `SPC_POS_W,
	parameter int SPD_W = `SPC_SPD_W,
	parameter int GAIN_W = `SPC_GAIN_W,
	parameter int PWM_W = `SPC_PWM_W,
	parameter int SHIFT_W = `SPC_SHIFT_W,
	parameter int SAMPLE_CYCLES = `SPC_SAMPLE_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_ce,
	input wire logic i_cmd_valid,
	input wire logic signed [POS_W-1:0] i_cmd_target,
	input wire logic [SPD_W-1:0] i_cmd_speed,
	input wire logic signed [POS_W-1:0] i_position,
	input wire logic signed [POS_W-1:0] i_velocity,
	input wire logic [POS_W-2:0] i_err_min,
	input wire logic [POS_W-2:0] i_int_max,
	input wire logic [GAIN_W-1:0] i_kp,
	input wire logic [GAIN_W-1:0] i_ki,
	input wire logic [GAIN_W-1:0] i_kd,
	input wire logic [SHIFT_W-1:0] i_scale_shift,
	input wire logic [PWM_W-1:0] i_pwm_limit,
	output logic [PWM_W-1:0] o_pwm_duty,
	output logic o_dir,
	output logic o_update,
	output logic o_profile_active,
	output logic signed [SPD_W:0] o_speed_setpoint,
	output logic [POS_W+1:0] o_profile_time
);
	localparam int TIME_W = POS_W + 2;
	localparam int CNT_W = $clog2(SAMPLE_CYCLES);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SAMPLE_CYCLES - 1);

	if (POS_W < 2 * SPD_W + 2 || PWM_W < 1 || PWM_W > POS_W || SAMPLE_CYCLES < 2
		|| SHIFT_W > 6)
	begin : g_bad_params
		$error("spc_controller: unsupported parameter values.");
	end

	////////////////////////////////////////////////////////////////////////////////

	// Magnitude of a signed value.
	function automatic logic [POS_W:0] mag_of(input logic signed [POS_W:0] v);
		mag_of = v[POS_W] ? $unsigned(-v) : $unsigned(v);
	endfunction

	// Ramp rate times a tick count, never above the speed ceiling.
	function automatic logic [SPD_W-1:0] ramp_speed(input logic [TIME_W-1:0] span,
		input logic [SPD_W-1:0] ceiling);
		logic [TIME_W-1:0] prod;
		prod = span * TIME_W'(`SPC_RAMP_RATE);
		ramp_speed = (prod > TIME_W'(ceiling)) ? ceiling : prod[SPD_W-1:0];
	endfunction

	logic [CNT_W-1:0] sample_cnt;
	logic tick;
	spc_pkg::spc_mode_t mode;
	logic signed [POS_W-1:0] target;
	logic heading;
	logic [SPD_W-1:0] ramp_up_span;
	logic [TIME_W-1:0] cruise_end;
	logic [TIME_W-1:0] finish;
	logic [TIME_W-1:0] decel_reference_tick;
	logic signed [POS_W:0] cmd_delta;
	logic [TIME_W-1:0] cmd_dist;
	logic [TIME_W-1:0] ramp_dist;
	logic [TIME_W-1:0] cmd_cruise;
	logic [SPD_W-1:0] next_setpoint;
	logic signed [POS_W-1:0] loop_err;
	logic [POS_W:0] err_abs;
	logic pos_saturate;
	logic loop_run;
	logic signed [POS_W-1:0] int_sum;
	logic signed [POS_W-1:0] prev_err;
	logic signed [POS_W-1:0] pid_next_int;
	logic [PWM_W-1:0] pid_duty;
	logic pid_dir;

	////////////////////////////////////////////////////////////////////////////////

	// Sample strobe, one cycle in every sample period.
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			sample_cnt <= '0;
		else if (i_ce)
			sample_cnt <= (sample_cnt == CNT_LAST) ? '0 : sample_cnt + 1'b1;
	end

	assign tick = i_ce && (sample_cnt == CNT_LAST);

	////////////////////////////////////////////////////////////////////////////////

	// Profile marks worked out from the incoming command.
	always_comb
	begin
		cmd_delta = (POS_W+1)'(i_cmd_target) - (POS_W+1)'(i_position);
		cmd_dist = TIME_W'(mag_of(cmd_delta));
		ramp_dist = TIME_W'(i_cmd_speed) * TIME_W'(i_cmd_speed);
		cmd_cruise = (cmd_dist > ramp_dist) ? cmd_dist - ramp_dist : '0;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			target <= '0;
			heading <= 1'b1;
			ramp_up_span <= '0;
			cruise_end <= '0;
			finish <= '0;
			decel_reference_tick <= '0;
		end
		else if (i_ce && i_cmd_valid)
		begin
			target <= i_cmd_target;
			heading <= ~cmd_delta[POS_W];
			if (i_cmd_speed != '0)
			begin
				ramp_up_span <= i_cmd_speed;
				cruise_end <= cmd_cruise;
				finish <= cmd_cruise + (TIME_W'(i_cmd_speed) << 1);
				decel_reference_tick <= cmd_cruise + (TIME_W'(i_cmd_speed) << 1);
			end
		end
	end

	// Operating mode.
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			mode <= spc_pkg::SPC_MODE_IDLE;
		else if (i_ce && i_cmd_valid)
			mode <= (i_cmd_speed != '0) ? spc_pkg::SPC_MODE_PROFILE
				: spc_pkg::SPC_MODE_POSITION;
		else if (tick)
		begin
			unique case (mode)
				spc_pkg::SPC_MODE_IDLE,
				spc_pkg::SPC_MODE_POSITION:
					mode <= mode;
				spc_pkg::SPC_MODE_PROFILE:
					if (o_profile_time >= finish)
						mode <= spc_pkg::SPC_MODE_POSITION;
			endcase
		end
	end

	assign o_profile_active = (mode == spc_pkg::SPC_MODE_PROFILE);

	// Profile time counter.
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			o_profile_time <= TIME_W'(`SPC_TIME_RESET);
		else if (i_ce && i_cmd_valid)
			o_profile_time <= '0;
		else if (tick && o_profile_active && o_profile_time < finish)
			o_profile_time <= o_profile_time + 1'b1;
	end

	// Speed setpoint for the present profile time.
	always_comb
	begin
		if (o_profile_time < TIME_W'(ramp_up_span))
			next_setpoint = ramp_speed(o_profile_time, ramp_up_span);
		else if (o_profile_time <= cruise_end)
			next_setpoint = ramp_up_span;
		else
			next_setpoint = ramp_speed(decel_reference_tick - o_profile_time,
				ramp_up_span);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			o_speed_setpoint <= '0;
		else if (i_ce && i_cmd_valid)
			o_speed_setpoint <= '0;
		else if (tick)
		begin
			if (!o_profile_active)
				o_speed_setpoint <= '0;
			else if (heading)
				o_speed_setpoint <= signed'({1'b0, next_setpoint});
			else
				o_speed_setpoint <= -signed'({1'b0, next_setpoint});
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// Loop error: velocity error during a profile, position error otherwise.
	always_comb
	begin
		if (o_profile_active)
			loop_err = POS_W'(o_speed_setpoint) - i_velocity;
		else
			loop_err = target - i_position;
	end

	assign err_abs = mag_of((POS_W+1)'(loop_err));
	assign pos_saturate = (mode == spc_pkg::SPC_MODE_POSITION)
		&& (err_abs > (POS_W+1)'(i_err_min));
	assign loop_run = tick && !i_cmd_valid && (mode != spc_pkg::SPC_MODE_IDLE);

	spc_pid_math #(
		.POS_W(POS_W),
		.GAIN_W(GAIN_W),
		.PWM_W(PWM_W),
		.SHIFT_W(SHIFT_W)
	) u_pid (
		.i_err(loop_err),
		.i_int_sum(int_sum),
		.i_prev_err(prev_err),
		.i_kp(i_kp),
		.i_ki(i_ki),
		.i_kd(i_kd),
		.i_int_max(i_int_max),
		.i_scale_shift(i_scale_shift),
		.i_pwm_limit(i_pwm_limit),
		.o_next_int_sum(pid_next_int),
		.o_pwm_duty(pid_duty),
		.o_dir(pid_dir)
	);

	// Integral sum and previous error.
	always_ff @(posedge i_clk)
	begin
		if (i_srst || (i_ce && i_cmd_valid))
		begin
			int_sum <= '0;
			prev_err <= '0;
		end
		else if (loop_run)
		begin
			if (!pos_saturate)
				int_sum <= pid_next_int;
			prev_err <= loop_err;
		end
	end

	// Drive value and direction, updated together once per sample.
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			o_pwm_duty <= '0;
			o_dir <= `SPC_DIR_RESET;
			o_update <= 1'b0;
		end
		else if (i_ce)
		begin
			o_update <= loop_run;
			if (loop_run && pos_saturate)
			begin
				o_pwm_duty <= '1;
				o_dir <= ~loop_err[POS_W-1];
			end
			else if (loop_run)
			begin
				o_pwm_duty <= pid_duty;
				o_dir <= pid_dir;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	logic signed [POS_W:0] sum_probe;
	logic signed [POS_W-1:0] sum_trunc;
	logic signed [POS_W:0] max_probe;
	logic [SPD_W:0] sp_mag;

	assign sum_probe = (POS_W+1)'(int_sum) + (POS_W+1)'(loop_err);
	assign sum_trunc = sum_probe[POS_W-1:0];
	assign max_probe = signed'({2'b00, i_int_max});
	assign sp_mag = o_speed_setpoint[SPD_W] ? $unsigned(-o_speed_setpoint)
		: $unsigned(o_speed_setpoint);

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);

	sat_drive_a: assert property (loop_run && pos_saturate |=> o_update && o_pwm_duty == '1)
		else $error("Large position error did not give full drive.");
	int_accum_a: assert property (loop_run && !pos_saturate && loop_err >= 0 && sum_probe >= 0
		&& sum_probe <= max_probe |=> int_sum == $past(sum_trunc))
		else $error("Integral sum did not accumulate the error.");
	int_clear_a: assert property (loop_run && !pos_saturate && loop_err > 0 && sum_probe < 0
		|=> int_sum == '0)
		else $error("Integral sum not cleared on sign change.");
	int_bound_a: assert property (o_update |-> int_sum <= max_probe && int_sum >= -max_probe)
		else $error("Integral sum outside its clamp.");
	prev_keep_a: assert property (loop_run |=> prev_err == $past(loop_err))
		else $error("Previous error not kept.");
	duty_limit_a: assert property (o_update |-> o_pwm_duty <= i_pwm_limit || o_pwm_duty == '1)
		else $error("Duty above limit but not at maximum.");
	cmd_profile_a: assert property (i_ce && i_cmd_valid && i_cmd_speed != '0
		|=> o_profile_active && o_profile_time == '0)
		else $error("Profile did not start on command.");
	cmd_position_a: assert property (i_ce && i_cmd_valid && i_cmd_speed == '0
		|=> mode == spc_pkg::SPC_MODE_POSITION)
		else $error("Zero speed command did not select position loop.");
	time_bound_a: assert property (o_profile_active |-> o_profile_time <= finish)
		else $error("Profile time passed the finish mark.");
	profile_end_a: assert property (tick && !i_cmd_valid && o_profile_active
		&& o_profile_time >= finish |=> mode == spc_pkg::SPC_MODE_POSITION)
		else $error("Profile did not hand over to the position loop.");
	ramp_up_a: assert property (tick && !i_cmd_valid && o_profile_active
		&& o_profile_time < TIME_W'(ramp_up_span)
		|=> sp_mag == (SPD_W+1)'($past(o_profile_time)))
		else $error("Ramp-up setpoint wrong.");
	cruise_hold_a: assert property (tick && !i_cmd_valid && o_profile_active
		&& o_profile_time >= TIME_W'(ramp_up_span) && o_profile_time <= cruise_end
		|=> sp_mag == (SPD_W+1)'(ramp_up_span))
		else $error("Cruise setpoint not at the speed ceiling.");

	profile_done_c: cover property (o_profile_active ##1 mode == spc_pkg::SPC_MODE_POSITION);
	saturate_c: cover property (loop_run && pos_saturate);
	int_clear_c: cover property (loop_run && !pos_saturate && loop_err > 0 && sum_probe < 0);
	decel_c: cover property (o_profile_active && o_profile_time > cruise_end && tick);
endmodule // spc_controller
`default_nettype wire

// file: tb/spc_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module spc_master_model #(
	parameter int POS_W = 32,
	parameter int SPD_W = 16
) (
	input wire logic i_clk,
	output logic o_cmd_valid,
	output logic signed [POS_W-1:0] o_cmd_target,
	output logic [SPD_W-1:0] o_cmd_speed
);
	initial
	begin
		o_cmd_valid = 1'b0;
		o_cmd_target = '0;
		o_cmd_speed = '0;
	end

	// Sends one position command as a single-cycle pulse; a zero speed asks for no profile.
	task automatic send(input logic signed [POS_W-1:0] target, input logic [SPD_W-1:0] speed);
		@(negedge i_clk);
		o_cmd_valid = 1'b1;
		o_cmd_target = target;
		o_cmd_speed = speed;
		@(negedge i_clk);
		o_cmd_valid = 1'b0;
		o_cmd_target = ~target;
		o_cmd_speed = ~speed;
	endtask
endmodule // spc_master_model
`default_nettype wire

// file: tb/servo_pid_profile_controller_bench.sv
`timescale 1ns/100ps
`default_nettype none
module servo_pid_profile_controller_bench;
	localparam int SC = 8;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic cmd_valid;
	logic signed [31:0] cmd_target;
	logic [15:0] cmd_speed;
	logic signed [31:0] position = '0;
	logic signed [31:0] velocity = '0;
	logic [7:0] duty;
	logic dir;
	logic update;
	logic active;
	logic signed [16:0] setpoint;
	logic [33:0] ptime;
	int seed = 32'h600140CF;
	int kp = 0;
	int ki = 0;
	int kd = 0;
	int emin = 50;
	int imax = 40;
	int lim = 100;
	int shift = 2;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;

	spc_controller #(.SAMPLE_CYCLES(SC)) u_spc_controller (
		.i_clk(clk),
		.i_srst(srst),
		.i_ce(ce),
		.i_cmd_valid(cmd_valid),
		.i_cmd_target(cmd_target),
		.i_cmd_speed(cmd_speed),
		.i_position(position),
		.i_velocity(velocity),
		.i_err_min(31'(emin)),
		.i_int_max(31'(imax)),
		.i_kp(16'(kp)),
		.i_ki(16'(ki)),
		.i_kd(16'(kd)),
		.i_scale_shift(5'(shift)),
		.i_pwm_limit(8'(lim)),
		.o_pwm_duty(duty),
		.o_dir(dir),
		.o_update(update),
		.o_profile_active(active),
		.o_speed_setpoint(setpoint),
		.o_profile_time(ptime)
	);

	spc_master_model u_spc_master_model (
		.i_clk(clk),
		.o_cmd_valid(cmd_valid),
		.o_cmd_target(cmd_target),
		.o_cmd_speed(cmd_speed)
	);

	////////////////////////////////////////////////////////////////////////////////
	always #12.5 clk = ~clk;

	always @(negedge clk) velocity <= 32'($random(seed) % 16);

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 6000)
		begin
			miscompares++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wait_update();
		int n = 0;
		@(negedge clk);
		while (update !== 1'b1 && n < 4 * SC)
		begin
			@(negedge clk);
			n++;
		end
		check(update, 1'b1);
	endtask

	task automatic check_idle();
		check(duty, 8'h00);
		check(dir, 1'b1);
		check(update, 1'b0);
		check(active, 1'b0);
		check(setpoint, 17'h00000);
		check(ptime, 34'h000000000);
	endtask

	function automatic int nsum(int e, int s);
		int r = s + e;
		if ((r < 0 && e > 0) || (r > 0 && e < 0)) r = 0;
		if (r > imax) r = imax;
		if (r < -imax) r = -imax;
		return r;
	endfunction

	function automatic logic [8:0] pid(int e, int s, int p);
		int o = (kp * e + ki * s + kd * (e - p)) >>> shift;
		int m = (o < 0) ? -o : o;
		return {o >= 0, (m > lim) ? 8'hFF : 8'(m)};
	endfunction

	function automatic int spf(int t, int sc, int cr, int fin);
		if (t < sc) return t;
		if (t <= cr) return sc;
		return (fin - t < sc) ? fin - t : sc;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		int e, ej, s, p, tgt, sp, d, cr, fin, tm, spx;
		logic [8:0] ex;
		int corner[8] = '{50, -50, 51, -51, 0, 30, -30, 7};
		int ps[3] = '{3, 3, 5};
		int po[3] = '{20, -20, 10};
		repeat (10) @(negedge clk);
		srst = 1'b0;
		check_idle();
		for (int i = 0; i < 10; i++)
		begin
			e = (i < 8) ? corner[i] : $random(seed) % 120;
			kp = $random(seed) & 15;
			shift = $random(seed) & 3;
			ki = $random(seed) & 15;
			kd = $random(seed) & 15;
			tgt = ($random(seed) % 1000) + e;
			position = 32'(tgt - e);
			u_spc_master_model.send(32'(tgt), 16'h0000);
			s = 0;
			p = 0;
			for (int j = 0; j < 3; j++)
			begin
				ej = (j == 2) ? -e : e;
				position = 32'(tgt - ej);
				if (ej > emin || -ej > emin)
					ex = {ej >= 0, 8'hFF};
				else
				begin
					s = nsum(ej, s);
					ex = pid(ej, s, p);
				end
				wait_update();
				check(duty, ex[7:0]);
				check(dir, ex[8]);
				check(active, 1'b0);
				p = ej;
			end
		end
		for (int t = 0; t < 3; t++)
		begin
			sp = ps[t];
			d = po[t];
			cr = ((d < 0) ? -d : d) - sp * sp;
			if (cr < 0) cr = 0;
			fin = cr + 2 * sp;
			u_spc_master_model.send(32'(position + d), 16'(sp));
			check(active, 1'b1);
			check(ptime, 34'h000000000);
			for (int k = 1; k <= fin + 2; k++)
			begin
				wait_update();
				tm = (k < fin) ? k : fin;
				// The setpoint of a sample follows the profile time held before that sample.
				spx = (k <= fin + 1) ? spf(k - 1, sp, cr, fin) : 0;
				if (d < 0) spx = -spx;
				check(ptime, 64'(tm));
				check(64'($signed(setpoint)), 64'(spx));
				if (k == fin - 1 || k == fin + 2) check(active, 1'(k < fin));
			end
		end
		@(negedge clk);
		ce = 1'b0;
		repeat (3 * SC)
		begin
			@(negedge clk);
			check(update, 1'b0);
		end
		ce = 1'b1;
		wait_update();
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		repeat (2 * SC) @(negedge clk);
		check_idle();
		end_sim();
	end
endmodule // servo_pid_profile_controller_bench
`default_nettype wire
